// ===== verilog/cffs_pkg.sv
/*
  Constants and types for the charger fault status and event flag bank.
  Assumes a single device clock; every user imports nothing and writes cffs_pkg::name.
*/
package cffs_pkg;

  // ************************************************************
  // Register indices (byte address is four times the index)
  // ************************************************************
  localparam logic [5:0] IDX_FAULT_STATUS_PRIMARY = 6'h20;
  localparam logic [5:0] IDX_FAULT_STATUS_SECONDARY = 6'h21;
  localparam logic [5:0] IDX_CHARGER_EVENT_FLAGS_A = 6'h22;
  localparam logic [5:0] IDX_CHARGER_EVENT_FLAGS_B = 6'h23;
  localparam logic [5:0] IDX_CHARGER_EVENT_FLAGS_C = 6'h24;
  localparam int unsigned REG_W = 8;
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam int unsigned FLAG_REGS = 2;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int unsigned SB_SYS_SHORT = 7;
  localparam int unsigned SB_SYS_OV = 6;
  localparam int unsigned SB_REV_OV = 5;
  localparam int unsigned SB_REV_UV = 4;
  localparam int unsigned SB_THERMAL_SHUT = 2;
  localparam int unsigned FA_CURRENT_LIMIT = 7;
  localparam int unsigned FA_VOLTAGE_LIMIT = 6;
  localparam int unsigned FA_WATCHDOG = 5;
  localparam int unsigned FA_WEAK_ADAPTER = 4;
  localparam int unsigned FA_QUALIFIED = 3;
  localparam int unsigned FA_INPUT_TWO = 2;
  localparam int unsigned FA_INPUT_ONE = 1;
  localparam int unsigned FA_BUS_PRESENT = 0;
  localparam int unsigned FB_CHARGE_STATE = 7;
  localparam int unsigned FB_OPTIMIZER = 6;
  localparam int unsigned FB_SOURCE_TYPE = 4;
  localparam int unsigned FB_THERMAL_REG = 2;
  localparam int unsigned FB_BATTERY = 1;
  localparam int unsigned FB_PORT_DETECT = 0;

  // ************************************************************
  // Types
  // ************************************************************
  // Order matches the primary then secondary fault status layouts, bit 7 first
  typedef struct packed {
    logic discharge_current_reg_status;
    logic bus_overvoltage_status;
    logic battery_overvoltage_status;
    logic bus_overcurrent_status;
    logic battery_overcurrent_status;
    logic converter_overcurrent_status;
    logic input_two_overvoltage_status;
    logic input_one_overvoltage_status;
    logic system_rail_short_status;
    logic system_rail_overvoltage_status;
    logic reverse_output_overvoltage_status;
    logic reverse_output_undervoltage_status;
    logic thermal_shutdown_status;
  } cffs_fault_t;

  typedef struct packed {
    logic input_current_reg;
    logic reverse_output_current_limit;
    logic input_voltage_reg;
    logic reverse_output_voltage_limit;
    logic host_watchdog_expired;
    logic weak_adapter_status;
    logic adapter_qualified_status;
    logic input_two_present;
    logic input_one_present;
    logic bus_present;
    logic [2:0] charge_state;
    logic [1:0] current_optimizer_state;
    logic [3:0] bus_source_type;
    logic thermal_regulation_active;
    logic battery_present;
    logic charging_port_detect_status;
  } cffs_evt_t;

endpackage

// ===== verilog/cffs_flag_if.sv
/*
  Carrier between the bank core and one sticky flag register.
  Assumes set and clear come from logic on the same clock as the register.
*/
`timescale 1ns/1ns
interface cffs_flag_if;
  logic [cffs_pkg::REG_W-1:0] set_bits;
  logic clear;
  logic [cffs_pkg::REG_W-1:0] flags;
  modport owner (input set_bits, input clear, output flags);
  modport user (output set_bits, output clear, input flags);
endinterface

// ===== verilog/cffs_sync.sv
/*
  Two flip-flop synchroniser for a bundle of slow asynchronous levels.
  Assumes each bit is a level that holds far longer than two clock periods.
*/
`timescale 1ns/1ns
module cffs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } cffs_sync_state_t;

  cffs_sync_state_t state_reg;
  cffs_sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end

  // Both stages clear on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule

// ===== verilog/cffs_sticky.sv
/*
  One eight-bit register of sticky event flags, cleared by a read strobe.
  Assumes set bits and the clear strobe are one-cycle pulses on hclk.
*/
`timescale 1ns/1ns
module cffs_sticky (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Flag carrier
  cffs_flag_if.owner flag
);

  typedef struct packed {
    logic [cffs_pkg::REG_W-1:0] flags;
  } cffs_sticky_state_t;

  cffs_sticky_state_t state_reg;
  cffs_sticky_state_t state_next;

  always_comb begin
    state_next.flags = (flag.clear ? cffs_pkg::REG_RESET : state_reg.flags) | flag.set_bits;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.flags <= cffs_pkg::REG_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign flag.flags = state_reg.flags;

endmodule

// ===== verilog/cffs_bank.sv
/*
  Charger fault status and event flag bank behind an AHB-Lite slave port.
  Assumes the condition inputs come from analog circuits, asynchronous to hclk,
  and that a single AHB-Lite master drives the port with word transfers.
*/
// What this block does
// - bit 7 primary shows discharge current regulation
// - bit 6 primary shows bus overvoltage
// - bit 5 primary shows battery overvoltage
// - bit 4 primary shows bus overcurrent
// - bit 3 primary shows battery overcurrent
// - bit 2 primary shows converter overcurrent
// - bits 1,0 primary show input overvoltage
// - all fields reset to zero, read-only
// - bit 7 secondary shows system short
// - bit 6 secondary shows system overvoltage
// - bits 5,4 secondary show reverse over/under
// - bit 2 secondary thermal shutdown, others zero
// - flag A7 on current regulation rise
// - flag A6 on voltage regulation rise
// - flag A5 on watchdog expiry rise
// - flag A4 on weak adapter rise
// - flag A3 on any qualified change
// - flags A2..A0 on presence changes
// - flags B7,B6 on charge/optimizer change
// - flag B4 on source type change
// - flag B2 on thermal regulation rise
// - flags B1,B0 battery/port detect change
`timescale 1ns/1ns
module cffs_bank (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Protection conditions
  input wire logic discharge_current_reg_status,
  input wire logic bus_overvoltage_status,
  input wire logic battery_overvoltage_status,
  input wire logic bus_overcurrent_status,
  input wire logic battery_overcurrent_status,
  input wire logic converter_overcurrent_status,
  input wire logic input_two_overvoltage_status,
  input wire logic input_one_overvoltage_status,
  input wire logic system_rail_short_status,
  input wire logic system_rail_overvoltage_status,
  input wire logic reverse_output_overvoltage_status,
  input wire logic reverse_output_undervoltage_status,
  input wire logic thermal_shutdown_status,
  // Regulation, detection and presence conditions
  input wire logic input_current_reg,
  input wire logic reverse_output_current_limit,
  input wire logic input_voltage_reg,
  input wire logic reverse_output_voltage_limit,
  input wire logic host_watchdog_expired,
  input wire logic weak_adapter_status,
  input wire logic adapter_qualified_status,
  input wire logic input_two_present,
  input wire logic input_one_present,
  input wire logic bus_present,
  input wire logic [2:0] charge_state,
  input wire logic [1:0] current_optimizer_state,
  input wire logic [3:0] bus_source_type,
  input wire logic thermal_regulation_active,
  input wire logic battery_present,
  input wire logic charging_port_detect_status
);

  // ************************************************************
  // Types and helpers
  // ************************************************************
  localparam int unsigned SYNC_W = $bits(cffs_pkg::cffs_fault_t) + $bits(cffs_pkg::cffs_evt_t);

  typedef struct packed {
    cffs_pkg::cffs_evt_t prev_evt;
    logic primed;
    logic [cffs_pkg::REG_W-1:0] status_primary;
    logic [cffs_pkg::REG_W-1:0] status_secondary;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
  } cffs_core_t;

  // Word decode of one register index; upper address bits must be zero
  function automatic logic reg_hit(input logic [31:0] addr, input logic [5:0] idx);
    reg_hit = (addr[31:8] == '0) && (addr[7:2] == idx);
  endfunction

  // Low-to-high transition between two samples
  function automatic logic rose(input logic now_lvl, input logic was_lvl);
    rose = now_lvl && !was_lvl;
  endfunction

  // ************************************************************
  // Signals
  // ************************************************************
  cffs_core_t state_reg;
  cffs_core_t state_next;
  cffs_pkg::cffs_fault_t fault_raw;
  cffs_pkg::cffs_evt_t evt_raw;
  cffs_pkg::cffs_fault_t fault_now;
  cffs_pkg::cffs_evt_t evt_now;
  logic [SYNC_W-1:0] sync_bus;
  logic addr_taken;
  logic read_taken;
  logic [cffs_pkg::REG_W-1:0] set_a;
  logic [cffs_pkg::REG_W-1:0] set_b;
  logic [cffs_pkg::REG_W-1:0] read_byte;
  logic current_now;
  logic current_was;
  logic voltage_now;
  logic voltage_was;

  cffs_flag_if flag_if[cffs_pkg::FLAG_REGS] ();

  // ************************************************************
  // Input capture
  // ************************************************************
  // Gather pins into the shared layouts
  always_comb begin
    fault_raw.discharge_current_reg_status = discharge_current_reg_status;
    fault_raw.bus_overvoltage_status = bus_overvoltage_status;
    fault_raw.battery_overvoltage_status = battery_overvoltage_status;
    fault_raw.bus_overcurrent_status = bus_overcurrent_status;
    fault_raw.battery_overcurrent_status = battery_overcurrent_status;
    fault_raw.converter_overcurrent_status = converter_overcurrent_status;
    fault_raw.input_two_overvoltage_status = input_two_overvoltage_status;
    fault_raw.input_one_overvoltage_status = input_one_overvoltage_status;
    fault_raw.system_rail_short_status = system_rail_short_status;
    fault_raw.system_rail_overvoltage_status = system_rail_overvoltage_status;
    fault_raw.reverse_output_overvoltage_status = reverse_output_overvoltage_status;
    fault_raw.reverse_output_undervoltage_status = reverse_output_undervoltage_status;
    fault_raw.thermal_shutdown_status = thermal_shutdown_status;
    evt_raw.input_current_reg = input_current_reg;
    evt_raw.reverse_output_current_limit = reverse_output_current_limit;
    evt_raw.input_voltage_reg = input_voltage_reg;
    evt_raw.reverse_output_voltage_limit = reverse_output_voltage_limit;
    evt_raw.host_watchdog_expired = host_watchdog_expired;
    evt_raw.weak_adapter_status = weak_adapter_status;
    evt_raw.adapter_qualified_status = adapter_qualified_status;
    evt_raw.input_two_present = input_two_present;
    evt_raw.input_one_present = input_one_present;
    evt_raw.bus_present = bus_present;
    evt_raw.charge_state = charge_state;
    evt_raw.current_optimizer_state = current_optimizer_state;
    evt_raw.bus_source_type = bus_source_type;
    evt_raw.thermal_regulation_active = thermal_regulation_active;
    evt_raw.battery_present = battery_present;
    evt_raw.charging_port_detect_status = charging_port_detect_status;
  end

  // Multi-bit states may skew by a cycle in the synchroniser; the only
  // cost is an extra change event, which a sticky flag absorbs anyway
  cffs_sync #(
    .WIDTH(SYNC_W)
  ) cffs_sync_inst (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in({fault_raw, evt_raw}),
    .sync_out(sync_bus)
  );

  // Split the synchronised bundle back apart
  assign {fault_now, evt_now} = sync_bus;

  // ************************************************************
  // Event detection
  // ************************************************************
  // Either direction of a regulation loop counts as one source
  assign current_now = evt_now.input_current_reg | evt_now.reverse_output_current_limit;
  assign current_was = state_reg.prev_evt.input_current_reg |
                       state_reg.prev_evt.reverse_output_current_limit;
  assign voltage_now = evt_now.input_voltage_reg | evt_now.reverse_output_voltage_limit;
  assign voltage_was = state_reg.prev_evt.input_voltage_reg |
                       state_reg.prev_evt.reverse_output_voltage_limit;

  // Edges only after one sample is held; prev_evt and the synchroniser both start at zero,
  // so levels present at reset release still raise events two cycles later
  always_comb begin
    set_a = cffs_pkg::REG_RESET;
    set_b = cffs_pkg::REG_RESET;
    if (state_reg.primed) begin
      set_a[cffs_pkg::FA_CURRENT_LIMIT] = rose(current_now, current_was);
      set_a[cffs_pkg::FA_VOLTAGE_LIMIT] = rose(voltage_now, voltage_was);
      set_a[cffs_pkg::FA_WATCHDOG] = rose(evt_now.host_watchdog_expired,
                                          state_reg.prev_evt.host_watchdog_expired);
      set_a[cffs_pkg::FA_WEAK_ADAPTER] = rose(evt_now.weak_adapter_status,
                                              state_reg.prev_evt.weak_adapter_status);
      set_a[cffs_pkg::FA_QUALIFIED] = evt_now.adapter_qualified_status !=
                                      state_reg.prev_evt.adapter_qualified_status;
      set_a[cffs_pkg::FA_INPUT_TWO] = evt_now.input_two_present !=
                                      state_reg.prev_evt.input_two_present;
      set_a[cffs_pkg::FA_INPUT_ONE] = evt_now.input_one_present !=
                                      state_reg.prev_evt.input_one_present;
      set_a[cffs_pkg::FA_BUS_PRESENT] = evt_now.bus_present != state_reg.prev_evt.bus_present;
      set_b[cffs_pkg::FB_CHARGE_STATE] = evt_now.charge_state != state_reg.prev_evt.charge_state;
      set_b[cffs_pkg::FB_OPTIMIZER] = evt_now.current_optimizer_state !=
                                      state_reg.prev_evt.current_optimizer_state;
      set_b[cffs_pkg::FB_SOURCE_TYPE] = evt_now.bus_source_type !=
                                        state_reg.prev_evt.bus_source_type;
      set_b[cffs_pkg::FB_THERMAL_REG] = rose(evt_now.thermal_regulation_active,
                                             state_reg.prev_evt.thermal_regulation_active);
      set_b[cffs_pkg::FB_BATTERY] = evt_now.battery_present != state_reg.prev_evt.battery_present;
      set_b[cffs_pkg::FB_PORT_DETECT] = evt_now.charging_port_detect_status !=
                                        state_reg.prev_evt.charging_port_detect_status;
    end
  end

  // ************************************************************
  // Sticky flag registers
  // ************************************************************
  // read clears its register
  assign flag_if[0].set_bits = set_a;
  assign flag_if[0].clear = read_taken && reg_hit(haddr, cffs_pkg::IDX_CHARGER_EVENT_FLAGS_A);
  assign flag_if[1].set_bits = set_b;
  assign flag_if[1].clear = read_taken && reg_hit(haddr, cffs_pkg::IDX_CHARGER_EVENT_FLAGS_B);

  // One identical register for each of flag words A and B
  for (genvar g = 0; g < cffs_pkg::FLAG_REGS; g++) begin : g_flags
    cffs_sticky cffs_sticky_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .flag(flag_if[g].owner)
    );
  end

  // ************************************************************
  // Bus slave
  // ************************************************************
  // Address phase qualifies on a busy-free NONSEQ or SEQ transfer
  assign addr_taken = hsel && hready && htrans[1];
  assign read_taken = addr_taken && !hwrite;

  // Read mux; unmapped words and the third flag word read zero
  always_comb begin
    read_byte = cffs_pkg::REG_RESET;
    if (reg_hit(haddr, cffs_pkg::IDX_FAULT_STATUS_PRIMARY)) begin
      read_byte = state_reg.status_primary;
    end else if (reg_hit(haddr, cffs_pkg::IDX_FAULT_STATUS_SECONDARY)) begin
      read_byte = state_reg.status_secondary;
    end else if (reg_hit(haddr, cffs_pkg::IDX_CHARGER_EVENT_FLAGS_A)) begin
      read_byte = flag_if[0].flags;
    end else if (reg_hit(haddr, cffs_pkg::IDX_CHARGER_EVENT_FLAGS_B)) begin
      read_byte = flag_if[1].flags;
    end
  end

  // ************************************************************
  // Next state
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    state_next.prev_evt = evt_now;
    state_next.primed = 1'b1;
    state_next.status_primary = {fault_now.discharge_current_reg_status,
                                 fault_now.bus_overvoltage_status,
                                 fault_now.battery_overvoltage_status,
                                 fault_now.bus_overcurrent_status,
                                 fault_now.battery_overcurrent_status,
                                 fault_now.converter_overcurrent_status,
                                 fault_now.input_two_overvoltage_status,
                                 fault_now.input_one_overvoltage_status};
    state_next.status_secondary = cffs_pkg::REG_RESET;
    state_next.status_secondary[cffs_pkg::SB_SYS_SHORT] = fault_now.system_rail_short_status;
    state_next.status_secondary[cffs_pkg::SB_SYS_OV] = fault_now.system_rail_overvoltage_status;
    state_next.status_secondary[cffs_pkg::SB_REV_OV] = fault_now.reverse_output_overvoltage_status;
    state_next.status_secondary[cffs_pkg::SB_REV_UV] =
      fault_now.reverse_output_undervoltage_status;
    state_next.status_secondary[cffs_pkg::SB_THERMAL_SHUT] = fault_now.thermal_shutdown_status;
    // Zero wait states and OKAY always; nothing here can stall or fail
    state_next.hreadyout = 1'b1;
    state_next.hresp = 1'b0;
    if (read_taken) begin
      state_next.hrdata = {24'h00_0000, read_byte};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg.prev_evt <= '0;
      state_reg.primed <= 1'b0;
      state_reg.status_primary <= cffs_pkg::REG_RESET;
      state_reg.status_secondary <= cffs_pkg::REG_RESET;
      state_reg.hreadyout <= 1'b1;
      state_reg.hresp <= 1'b0;
      state_reg.hrdata <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign hreadyout = state_reg.hreadyout;
  assign hresp = state_reg.hresp;
  assign hrdata = state_reg.hrdata;

endmodule

// ===== bench/cffs_bank_properties.sv
/*
  Checker for the fault and flag bank, bound to its top module.
  Assumes one master and hready tied to hreadyout.
*/
`timescale 1ns/1ns
module cffs_bank_properties (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Conditions
  input wire logic discharge_current_reg_status,
  input wire logic input_one_overvoltage_status,
  input wire logic system_rail_short_status,
  input wire logic thermal_shutdown_status
);
  // ********
  // Helpers
  // ********
  logic [2:0] up;
  wire dc = discharge_current_reg_status;
  wire i1 = input_one_overvoltage_status;
  wire ss = system_rail_short_status;
  wire ts = thermal_shutdown_status;
  wire rd = hsel && hready && htrans[1] && !hwrite;
  wire wr = hsel && hready && htrans[1] && hwrite;
  wire ok = (up == 3'h7);
  // Settle count keeps $past clear of values seen in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ********
  // Properties
  // ********
  property p_okay;
    hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or not okay");
  property p_upper;
    rd |=> hrdata[31:8] == 24'h00_0000;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_prim7;
    rd && ok && haddr == 32'h0000_0080 && $past(dc) == dc && $past(dc, 2) == dc
      && $past(dc, 3) == dc |=> hrdata[7] == $past(dc);
  endproperty
  a_prim7: assert property (p_prim7) else $error("discharge bit wrong");
  property p_prim0;
    rd && ok && haddr == 32'h0000_0080 && $past(i1) == i1 && $past(i1, 2) == i1
      && $past(i1, 3) == i1 |=> hrdata[0] == $past(i1);
  endproperty
  a_prim0: assert property (p_prim0) else $error("input one bit wrong");
  property p_sec7;
    rd && ok && haddr == 32'h0000_0084 && $past(ss) == ss && $past(ss, 2) == ss
      && $past(ss, 3) == ss |=> hrdata[7] == $past(ss);
  endproperty
  a_sec7: assert property (p_sec7) else $error("short bit wrong");
  property p_sec2;
    rd && ok && haddr == 32'h0000_0084 && $past(ts) == ts && $past(ts, 2) == ts
      && $past(ts, 3) == ts |=> hrdata[2] == $past(ts);
  endproperty
  a_sec2: assert property (p_sec2) else $error("thermal bit wrong");
  property p_secres;
    rd && haddr == 32'h0000_0084 |=> !hrdata[3] && hrdata[1:0] == 2'h0;
  endproperty
  a_secres: assert property (p_secres) else $error("reserved bit set");
  property p_wr;
    wr |=> $stable(hrdata);
  endproperty
  a_wr: assert property (p_wr) else $error("write changed read data");
endmodule
bind cffs_bank cffs_bank_properties cffs_bank_properties_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .discharge_current_reg_status(discharge_current_reg_status),
  .input_one_overvoltage_status(input_one_overvoltage_status),
  .system_rail_short_status(system_rail_short_status),
  .thermal_shutdown_status(thermal_shutdown_status)
);

// ===== bench/tb_cffs_bank.sv
/*
  Self-checking bench for the fault and flag bank.
  Assumes zero wait states are possible but waits on hreadyout anyway.
*/
`timescale 1ns/1ns
module tb_cffs_bank;
  // ********
  // Signals
  // ********
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0] htrans, co;
  logic [2:0] hsize, cs;
  logic [3:0] st;
  logic [12:0] f, e;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc = 0;
  cffs_bank cffs_bank_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .discharge_current_reg_status(f[12]), .bus_overvoltage_status(f[11]),
    .battery_overvoltage_status(f[10]), .bus_overcurrent_status(f[9]),
    .battery_overcurrent_status(f[8]), .converter_overcurrent_status(f[7]),
    .input_two_overvoltage_status(f[6]), .input_one_overvoltage_status(f[5]),
    .system_rail_short_status(f[4]), .system_rail_overvoltage_status(f[3]),
    .reverse_output_overvoltage_status(f[2]), .reverse_output_undervoltage_status(f[1]),
    .thermal_shutdown_status(f[0]), .input_current_reg(e[12]),
    .reverse_output_current_limit(e[11]), .input_voltage_reg(e[10]),
    .reverse_output_voltage_limit(e[9]), .host_watchdog_expired(e[8]),
    .weak_adapter_status(e[7]), .adapter_qualified_status(e[6]),
    .input_two_present(e[5]), .input_one_present(e[4]), .bus_present(e[3]),
    .charge_state(cs), .current_optimizer_state(co), .bus_source_type(st),
    .thermal_regulation_active(e[2]), .battery_present(e[1]),
    .charging_port_detect_status(e[0])
  );
  // ********
  // Clock, guard and tasks
  // ********
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // Hang guard, far above the few hundred cycles needed
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt = error_cnt + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks = num_checks + 1;
    if (g !== x) begin
      error_cnt = error_cnt + 1;
      $display("FAIL at %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Single word transfer, entered just after an edge; data taken at the data phase edge
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rdat = hrdata;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x);
    xfer(1'b0, a, 32'h0000_0000);
    chk(rdat, x);
  endtask
  // Covers two sync stages, the status stage and margin
  task automatic wt();
    repeat (5) @(posedge hclk);
  endtask
  // Slots 13 to 15 are the multi-bit state codes
  task automatic drv(input int k, input logic v);
    case (k)
      13: cs <= v ? 3'h5 : 3'h0;
      14: co <= v ? 2'h2 : 2'h0;
      15: st <= v ? 4'h9 : 4'h0;
      default: e[k] <= v;
    endcase
  endtask
  // ********
  // Scenarios
  // ********
  task automatic t_reset();
    for (int i = 0; i < 5; i++) begin
      rd(32'h0000_0080 + 32'(4 * i), 32'h0000_0000);
    end
    rd(32'h0000_00FC, 32'h0000_0000);
  endtask
  // One live condition at a time, then all together
  task automatic t_status();
    logic [7:0] sm [5] = '{8'h04, 8'h10, 8'h20, 8'h40, 8'h80};
    for (int i = 0; i < 8; i++) begin
      f <= 13'(1 << (i + 5));
      wt();
      rd(32'h0000_0080, 32'(1 << i));
    end
    for (int j = 0; j < 5; j++) begin
      f <= 13'(1 << j);
      wt();
      rd(32'h0000_0084, {24'h00_0000, sm[j]});
    end
    f <= 13'h1FFF;
    wt();
    rd(32'h0000_0084, 32'h0000_00F4);
    rd(32'h0000_0080, 32'h0000_00FF);
    f <= 13'h0000;
    wt();
    rd(32'h0000_0080, 32'h0000_0000);
  endtask
  // Each source rises then falls; change sources flag both ways, edge sources once
  task automatic t_flags();
    logic [15:0] x;
    logic [15:0] rise [16] = '{16'h0001, 16'h0002, 16'h0004, 16'h0100, 16'h0200,
      16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000, 16'h4000, 16'h8000,
      16'h8000, 16'h0080, 16'h0040, 16'h0010};
    logic [15:0] chg = 16'hE07B;
    for (int k = 0; k < 16; k++) begin
      x = chg[k] ? rise[k] : 16'h0000;
      drv(k, 1'b1);
      wt();
      rd(32'h0000_0088, {24'h00_0000, rise[k][15:8]});
      rd(32'h0000_008C, {24'h00_0000, rise[k][7:0]});
      rd(32'h0000_0088, 32'h0000_0000);
      drv(k, 1'b0);
      wt();
      rd(32'h0000_0088, {24'h00_0000, x[15:8]});
      rd(32'h0000_008C, {24'h00_0000, x[7:0]});
    end
  endtask
  // Writes leave a pending flag and the status alone
  task automatic t_write();
    e[3] <= 1'b1;
    wt();
    xfer(1'b1, 32'h0000_0088, 32'hFFFF_FFFF);
    xfer(1'b1, 32'h0000_0080, 32'hFFFF_FFFF);
    rd(32'h0000_0080, 32'h0000_0000);
    rd(32'h0000_0088, 32'h0000_0001);
  endtask
  // Event landing on the clearing read edge survives the clear
  task automatic t_race();
    drv(3, 1'b0);
    repeat (2) @(posedge hclk);
    rd(32'h0000_0088, 32'h0000_0000);
    rd(32'h0000_0088, 32'h0000_0001);
  endtask
  initial begin
    hresetn = 1'b0;
    {hsel, hwrite, haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    {f, e, cs, co, st} = '0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    t_reset();
    t_status();
    t_flags();
    t_write();
    t_race();
    stop_test();
  end
endmodule
